// file: logic/flash_supervisor_indicator_ctrl.sv
// supervisor, indicator and self-calibration logic of the flash driver
//
// Overview of operation
// - power-good active only in voltage regulation
// - shutdown: ready pin low or released
// - push-pull active high, open-drain active low
// - power-ok only inside -1.5/+2.5 percent window
// - power-ok low when voltage mode suspended
// - power-ok low while recycling energy downward
// - thermistor watch in light modes, gated otherwise
// - warm flag below 1.05 V, keep running
// - overheat below 0.345 V latches, shuts down in light modes only
// - die flags warn only, off in shutdown unless overheat latched
// - block switches below 2.3 V battery
// - ground output only when fully off
// - fixed 30 kHz pwm, duty from level
// - dimming only software dc-light, selected sinks
// - calibration start sweeps from minimum voltage
// - step voltage, strobe, judge sink headroom
// - high-current strobe with power stage off
// - stop at headroom, store voltage, set flag
// - flag clears at start; reads give result
// - current modes without voltage regulation
`timescale 1ns/100ps
`include "flash_sup_map.svh"
module flash_supervisor_indicator_ctrl #(
	parameter int PWM_CYCLES = `PWM_CYCLES,
	parameter int STROBE_CYCLES = `STROBE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire flash_sup_pkg::sense_t sense_i,
	output logic ready_out_o,
	output logic ready_oe_o,
	output logic power_ok_flag_o,
	output logic led_warm_flag_o,
	output logic led_overheat_flag_o,
	output logic junction_temp_flags_o,
	output logic therm_active_o,
	output logic switch_allow_o,
	output logic power_stage_on_o,
	output logic boost_output_ground_o,
	output logic [2:0] sink_drive_o,
	output logic safety_timer_en_o,
	output logic current_only_o,
	output logic [3:0] boost_output_target_o,
	output logic strobe_o
);
	import flash_sup_pkg::*;

	// 16-bit counters bound both periods
	if (PWM_CYCLES < 256 || PWM_CYCLES > 65535)
	begin : g_bad_pwm
		$error("pwm period out of range");
	end
	if (STROBE_CYCLES < 1 || STROBE_CYCLES > 65535)
	begin : g_bad_strobe
		$error("strobe length out of range");
	end

	typedef struct packed {
		ctrl_t ctrl;
		logic calibration_flag;
		logic cal_start;
		cal_state_t cal_state;
		logic [3:0] cal_ov;
		logic [3:0] cal_result;
		logic [15:0] cnt;
		logic [15:0] pwm_cnt;
		logic led_overheat;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] s1_hot;
		logic [1:0] s1_warm;
		logic [1:0] s1_die;
		logic [1:0] s1_batt;
		logic [1:0] s1_low;
		logic [1:0] s1_high;
		logic [1:0] s1_rec;
		logic [2:0] hr_a;
		logic [2:0] hr_b;
	} state_t;

	state_t st_r, st_nxt;
	logic req, vreg, light, therm_on, pok, cal_busy, dim_on, pwm_hi;
	logic [2:0] hr_ok;

	assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	// voltage regulation active
	assign vreg = (st_r.ctrl.mode == `MODE_VOLT) |
		st_r.ctrl.voltage_mode_enable;
	assign light = (st_r.ctrl.mode == `MODE_DC) |
		(st_r.ctrl.mode == `MODE_FLASH);
	assign therm_on = light |
		((st_r.ctrl.mode == `MODE_VOLT) & st_r.ctrl.thermistor_enable);
	assign cal_busy = (st_r.cal_state != CAL_IDLE);
	assign pok = vreg & ~st_r.s1_low[1] & ~st_r.s1_high[1] &
		~st_r.s1_rec[1];
	assign dim_on = (st_r.ctrl.mode == `MODE_DC) &
		st_r.ctrl.voltage_mode_enable &
		(st_r.ctrl.indicator_level_field != 8'h00);
	// fixed-period pwm, duty from level
	// scaled compare: duty stays level/256 for any period length, full at level FF
	assign pwm_hi = ({8'h00, st_r.pwm_cnt, 8'h00} <
		(32'(st_r.ctrl.indicator_level_field) * 32'(PWM_CYCLES))) |
		(st_r.ctrl.indicator_level_field == 8'hFF);
	assign hr_ok = st_r.hr_b | ~st_r.ctrl.sink_enable_bits;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = req;
		st_nxt.cal_start = 1'b0;
		st_nxt.s1_hot = {st_r.s1_hot[0], sense_i.therm_hot};
		st_nxt.s1_warm = {st_r.s1_warm[0], sense_i.therm_warm};
		st_nxt.s1_die = {st_r.s1_die[0], sense_i.die_hot};
		st_nxt.s1_batt = {st_r.s1_batt[0], sense_i.batt_ok};
		st_nxt.s1_low = {st_r.s1_low[0], sense_i.boost_output_low};
		st_nxt.s1_high = {st_r.s1_high[0], sense_i.boost_output_high};
		st_nxt.s1_rec = {st_r.s1_rec[0], sense_i.recycling};
		st_nxt.hr_a = sense_i.headroom_ok;
		st_nxt.hr_b = st_r.hr_a;
		if (st_r.pwm_cnt >= 16'(PWM_CYCLES - 1))
			st_nxt.pwm_cnt = 16'h0000;
		else
			st_nxt.pwm_cnt = st_r.pwm_cnt + 16'h0001;
		if (req)
		begin
			unique case (wb_adr_i)
				`ADR_CTRL: st_nxt.rdata = 32'(st_r.ctrl[20:4]);
				`ADR_CAL: st_nxt.rdata = {31'h0, st_r.calibration_flag};
				`ADR_STATUS: st_nxt.rdata = {26'h0, st_r.s1_batt[1],
					junction_temp_flags_o, st_r.led_overheat,
					led_warm_flag_o, pok, cal_busy};
				`ADR_OV: st_nxt.rdata = {28'h0, st_r.calibration_flag ?
					st_r.cal_result : st_r.ctrl.output_voltage_field};
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (req & wb_we_i)
		begin
			if (wb_adr_i == `ADR_CTRL)
			begin
				if (wb_sel_i[0])
				begin
					st_nxt.ctrl.mode = wb_dat_i[1:0];
					st_nxt.ctrl.voltage_mode_enable = wb_dat_i[2];
					st_nxt.ctrl.output_stage_select = wb_dat_i[3];
					st_nxt.ctrl.thermistor_enable = wb_dat_i[4];
					st_nxt.ctrl.high_current_select = wb_dat_i[5];
				end
				if (wb_sel_i[1])
					st_nxt.ctrl.sink_enable_bits = wb_dat_i[10:8];
				if (wb_sel_i[2])
					st_nxt.ctrl.indicator_level_field = wb_dat_i[23:16];
			end
			if (wb_adr_i == `ADR_OV && wb_sel_i[0])
				st_nxt.ctrl.output_voltage_field = wb_dat_i[3:0];
			if (wb_adr_i == `ADR_CAL && wb_sel_i[0] && wb_dat_i[0] &&
				!cal_busy)
				st_nxt.cal_start = 1'b1;
		end
		if (light & st_r.s1_hot[1])
		begin
			st_nxt.led_overheat = 1'b1;
			st_nxt.ctrl.mode = `MODE_OFF;
		end
		else if (req & wb_we_i & (wb_adr_i == `ADR_STATUS) & wb_dat_i[3])
			st_nxt.led_overheat = 1'b0;
		unique case (st_r.cal_state)
			CAL_IDLE:
				if (st_r.cal_start)
				begin
					st_nxt.calibration_flag = 1'b0;
					st_nxt.cal_ov = `OV_MIN;
					st_nxt.cnt = 16'(STROBE_CYCLES);
					st_nxt.cal_state = CAL_SETTLE;
				end
			CAL_SETTLE:
				if (st_r.cnt == 16'h0000)
				begin
					st_nxt.cnt = 16'(STROBE_CYCLES);
					st_nxt.cal_state = CAL_STROBE;
				end
				else
					st_nxt.cnt = st_r.cnt - 16'h0001;
			CAL_STROBE:
				if (st_r.cnt == 16'h0000)
					st_nxt.cal_state = CAL_JUDGE;
				else
					st_nxt.cnt = st_r.cnt - 16'h0001;
			CAL_JUDGE:
			begin
				if ((&hr_ok) || st_r.cal_ov == `OV_MAX)
				begin
					st_nxt.cal_result = st_r.cal_ov;
					st_nxt.ctrl.output_voltage_field = st_r.cal_ov;
					st_nxt.calibration_flag = 1'b1;
					st_nxt.cal_state = CAL_IDLE;
				end
				else
				begin
					st_nxt.cal_ov = st_r.cal_ov + 4'h1;
					st_nxt.cnt = 16'(STROBE_CYCLES);
					st_nxt.cal_state = CAL_SETTLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
			st_r.cal_state <= CAL_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;
	assign power_ok_flag_o = pok;
	assign ready_out_o = st_r.ctrl.output_stage_select ? 1'b0 : pok;
	assign ready_oe_o = st_r.ctrl.output_stage_select ? pok : 1'b1;
	assign therm_active_o = therm_on;
	assign led_warm_flag_o = therm_on & st_r.s1_warm[1];
	assign led_overheat_flag_o = st_r.led_overheat;
	assign junction_temp_flags_o = (st_r.ctrl.mode != `MODE_OFF) &
		st_r.s1_die[1] | st_r.led_overheat;
	assign switch_allow_o = st_r.s1_batt[1];
	assign power_stage_on_o = st_r.s1_batt[1] &
		(st_r.ctrl.mode != `MODE_OFF | st_r.ctrl.voltage_mode_enable |
		cal_busy) &
		~(cal_busy & (st_r.cal_state == CAL_STROBE) &
		st_r.ctrl.high_current_select);
	assign boost_output_ground_o = (st_r.ctrl.mode == `MODE_OFF) &
		~st_r.ctrl.voltage_mode_enable & ~st_r.ctrl.high_current_select &
		~cal_busy;
	assign sink_drive_o = st_r.ctrl.sink_enable_bits &
		{3{(dim_on ? pwm_hi : light) | strobe_o}};
	assign safety_timer_en_o = light & ~dim_on;
	assign current_only_o = light & ~st_r.ctrl.voltage_mode_enable;
	assign boost_output_target_o = cal_busy ? st_r.cal_ov :
		st_r.ctrl.output_voltage_field;
	assign strobe_o = (st_r.cal_state == CAL_STROBE);
endmodule : flash_supervisor_indicator_ctrl

// file: pkg/flash_sup_map.svh
// register offsets, mode codes, reset values and timing counts
`ifndef FLASH_SUP_MAP_SVH
`define FLASH_SUP_MAP_SVH
`define ADR_CTRL 4'h0
`define ADR_CAL 4'h1
`define ADR_STATUS 4'h2
`define ADR_OV 4'h3
`define CTRL_RESET 32'h0000_0000
`define OV_W 4
`define OV_MIN 4'h0
`define OV_MAX 4'hF
`define MODE_OFF 2'b00
`define MODE_DC 2'b01
`define MODE_FLASH 2'b10
`define MODE_VOLT 2'b11
`define CLK_HZ 100000000
`define PWM_HZ 30000
`define PWM_CYCLES (`CLK_HZ / `PWM_HZ)
`define STROBE_US 10
`define STROBE_CYCLES (`STROBE_US * (`CLK_HZ / 1000000))
`endif

// file: pkg/flash_sup_pkg.sv
// types of the flash supervisor block
package flash_sup_pkg;
	typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_STROBE, CAL_JUDGE} cal_state_t;
	typedef struct packed {
		logic [1:0] mode;
		logic voltage_mode_enable;
		logic output_stage_select;
		logic thermistor_enable;
		logic high_current_select;
		logic [2:0] sink_enable_bits;
		logic [7:0] indicator_level_field;
		logic [3:0] output_voltage_field;
	} ctrl_t;
	typedef struct packed {
		logic boost_output_low;
		logic boost_output_high;
		logic recycling;
		logic therm_warm;
		logic therm_hot;
		logic die_hot;
		logic batt_ok;
		logic [2:0] headroom_ok;
	} sense_t;
endpackage : flash_sup_pkg

// file: tb/flash_sup_assertions.sv
// concurrent checks on the flash supervisor ports
`timescale 1ns/100ps
module flash_sup_checker #(
	parameter int STROBE_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire flash_sup_pkg::sense_t sense_i,
	input wire logic ready_out_o,
	input wire logic ready_oe_o,
	input wire logic power_ok_flag_o,
	input wire logic led_warm_flag_o,
	input wire logic led_overheat_flag_o,
	input wire logic junction_temp_flags_o,
	input wire logic power_stage_on_o,
	input wire logic boost_output_ground_o,
	input wire logic current_only_o,
	input wire logic strobe_o
);
	import flash_sup_pkg::*;
	logic [15:0] high_r;
	// strobe width counter, a repeat would unroll too far
	always_ff @(posedge clk_i)
		if (rst_i)
			high_r <= 16'h0000;
		else if (strobe_o)
			high_r <= high_r + 16'h0001;
		else
			high_r <= 16'h0000;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_pin; ready_out_o |-> ready_oe_o && power_ok_flag_o; endproperty
	a_pin: assert property (p_pin) else $error("pin high wrongly");
	property p_od; !ready_oe_o |-> !power_ok_flag_o && !ready_out_o; endproperty
	a_od: assert property (p_od) else $error("pin released wrongly");
	property p_win; power_ok_flag_o |-> !$past(sense_i.boost_output_low, 2) &&
		!$past(sense_i.boost_output_high, 2) && !$past(sense_i.recycling, 2); endproperty
	a_win: assert property (p_win) else $error("power ok out of window");
	property p_cur; current_only_o |-> !power_ok_flag_o; endproperty
	a_cur: assert property (p_cur) else $error("power ok in current mode");
	property p_sw; power_stage_on_o |-> $past(sense_i.batt_ok, 2); endproperty
	a_sw: assert property (p_sw) else $error("switching on low battery");
	property p_gnd; boost_output_ground_o |-> !power_stage_on_o; endproperty
	a_gnd: assert property (p_gnd) else $error("ground while running");
	property p_warm; led_warm_flag_o |-> $past(sense_i.therm_warm, 2); endproperty
	a_warm: assert property (p_warm) else $error("warm flag false");
	property p_hot; $rose(led_overheat_flag_o) |-> $past(sense_i.therm_hot, 3)
		##[0:2] (junction_temp_flags_o && !current_only_o); endproperty
	a_hot: assert property (p_hot) else $error("overheat handling");
	property p_str; $fell(strobe_o) |-> high_r == STROBE_CYCLES + 1; endproperty
	a_str: assert property (p_str) else $error("strobe width");
	c_str: cover property ($fell(strobe_o));
	c_hot: cover property ($rose(led_overheat_flag_o));
	c_pok: cover property ($rose(power_ok_flag_o));
endmodule : flash_sup_checker
bind flash_supervisor_indicator_ctrl flash_sup_checker #(
	.STROBE_CYCLES(STROBE_CYCLES)
) u_flash_sup_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.sense_i, .ready_out_o, .ready_oe_o, .power_ok_flag_o, .led_warm_flag_o,
	.led_overheat_flag_o, .junction_temp_flags_o, .power_stage_on_o,
	.boost_output_ground_o, .current_only_o, .strobe_o);

// file: tb/host_model.sv
// host processor model: classic wishbone master
`timescale 1ns/100ps
module host_model (
	input wire logic clk_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [3:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o
);
	initial
	begin
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o} = 7'h00;
		{wb_sel_o, wb_dat_o} = 36'h0_0000_0000;
	end
	// called just after an edge; holds all until ack is sampled
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o} <= {2'b11, w, a};
		wb_sel_o <= 4'hF;
		wb_dat_o <= d;
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		{wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
		@(posedge clk_i);
	endtask : xfer
endmodule : host_model

// file: tb/testbench.sv
// self-checking bench of the flash supervisor block
`timescale 1ns/100ps
`include "flash_sup_map.svh"
module testbench;
	import flash_sup_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic ready_out_o, ready_oe_o, current_only_o, switch_allow_o, safe_o;
	logic therm_active_o, boost_output_ground_o, power_stage_on_o, strobe_o;
	logic [2:0] sink_drive_o;
	int strobe_cnt = 0;
	int stage_cnt = 0;
	sense_t sense_i = '0;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	initial forever #5 clk_i = ~clk_i;
	host_model u_host_model (.clk_i(clk_i), .wb_ack_i(wb_ack_o),
		.wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
		.wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
		.wb_dat_o(wb_dat_i));
	// short strobe keeps the sweep brief
	flash_supervisor_indicator_ctrl #(.PWM_CYCLES(256), .STROBE_CYCLES(4))
	u_flash_supervisor_indicator_ctrl (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.sense_i, .ready_out_o, .ready_oe_o, .power_ok_flag_o(),
		.led_warm_flag_o(), .led_overheat_flag_o(), .junction_temp_flags_o(),
		.therm_active_o, .switch_allow_o, .power_stage_on_o,
		.boost_output_ground_o, .sink_drive_o,
		.safety_timer_en_o(safe_o), .current_only_o, .boost_output_target_o(),
		.strobe_o);
	// strobe cycles and strobe cycles with the power stage running
	always @(negedge clk_i)
	begin
		if (strobe_o)
			strobe_cnt++;
		if (strobe_o & power_stage_on_o)
			stage_cnt++;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		u_host_model.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		u_host_model.xfer(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask : rchk
	// sense passes two sync stages, so wait past them
	task automatic sns(input logic [9:0] v);
		sense_i <= v;
		repeat (4) @(posedge clk_i);
	endtask : sns
	task automatic pins(input logic [7:0] e);
		@(negedge clk_i);
		chk({24'h0, therm_active_o, boost_output_ground_o, power_stage_on_o,
			ready_oe_o, ready_out_o, current_only_o, safe_o,
			switch_allow_o}, {24'h0, e});
		@(posedge clk_i);
	endtask : pins
	// high cycles of the first sink over one pwm period
	task automatic duty(input logic [31:0] e);
		int n;
		n = 0;
		repeat (256)
		begin
			@(negedge clk_i);
			if (sink_drive_o == 3'b001)
				n++;
		end
		@(posedge clk_i);
		chk(32'(n), e);
	endtask : duty
	task automatic calwait;
		q = 32'h0000_0000;
		for (int i = 0; i < 100 && q[0] !== 1'b1; i++)
			u_host_model.xfer(1'b0, `ADR_CAL, 32'h0000_0000, q);
	endtask : calwait
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk(`ADR_CTRL, `CTRL_RESET);
		wr(4'h7, 32'hFFFF_FFFF);
		rchk(4'h7, 32'h0000_0000);
		wr(`ADR_CTRL, 32'h00FF_0713);
		rchk(`ADR_CTRL, 32'h0001_97FF);
		sns(10'h008);
		rchk(`ADR_STATUS, 32'h0000_0022);
		sns(10'h108);
		rchk(`ADR_STATUS, 32'h0000_0020);
		sns(10'h088);
		rchk(`ADR_STATUS, 32'h0000_0020);
		sns(10'h008);
		wr(`ADR_CTRL, 32'h0000_000B);
		pins(8'b00110001);
		sns(10'h108);
		pins(8'b00100001);
		sns(10'h008);
		wr(`ADR_CTRL, 32'h0000_0008);
		pins(8'b01000001);
		wr(`ADR_CTRL, 32'h0000_0000);
		pins(8'b01010001);
		wr(`ADR_CTRL, 32'h0000_0004);
		rchk(`ADR_STATUS, 32'h0000_0022);
		wr(`ADR_CTRL, 32'h0000_0001);
		sns(10'h048);
		rchk(`ADR_STATUS, 32'h0000_0024);
		wr(`ADR_CTRL, 32'h0080_0105);
		sns(10'h000);
		pins(8'b10011000);
		duty(32'h0000_0080);
		sns(10'h008);
		wr(`ADR_CTRL, 32'h0000_0002);
		sns(10'h028);
		rchk(`ADR_STATUS, 32'h0000_0038);
		rchk(`ADR_CTRL, 32'h0000_0000);
		sns(10'h008);
		wr(`ADR_STATUS, 32'h0000_0008);
		rchk(`ADR_STATUS, 32'h0000_0020);
		wr(`ADR_CTRL, 32'h0000_0700);
		sns(10'h00F);
		wr(`ADR_CAL, 32'h0000_0001);
		calwait();
		rchk(`ADR_CAL, 32'h0000_0001);
		rchk(`ADR_OV, {28'h0, `OV_MIN});
		sns(10'h008);
		wr(`ADR_CTRL, 32'h0000_0720);
		wr(`ADR_CAL, 32'h0000_0001);
		calwait();
		rchk(`ADR_OV, {28'h0, `OV_MAX});
		chk(32'(strobe_cnt), 32'h0000_0055);
		chk(32'(stage_cnt), 32'h0000_0005);
		pins(8'b00010001);
		report_and_stop();
	end
endmodule : testbench
